// ==== qdc_pkg.sv ====
// Shared constants for the three-axis quadrature decoder.
package qdc_pkg;
  // Clock rate and the highest permitted sampling rate, in MHz.
  localparam int SYS_CLK_MHZ  = 100;
  localparam int SAMP_MAX_MHZ = 32;
  // Least sampling period in system cycles, rounded up.
  localparam int SAMP_MIN_CYC = (SYS_CLK_MHZ + SAMP_MAX_MHZ - 1) / SAMP_MAX_MHZ;
  // Widths of counters, selects, divider and address.
  localparam int AXIS_W   = 16;
  localparam int EVT_W    = 8;
  localparam int NUM_GPIO = 32;
  localparam int SEL_W    = 5;
  localparam int DIV_W    = 10;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int FILT_LEN = 3;
  // Register byte offsets.
  localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_DIVIDER  = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_X_STEPS  = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_Y_STEPS  = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_Z_STEPS  = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_EDGE_CNT = 8'h18;
  // Field positions in decoder_control_one.
  localparam int CT1_IRQ_EN  = 0;
  localparam int CT1_PENDING = 1;
  localparam int CT1_CLEAR   = 2;
  localparam int CT1_THR_LSB = 8;
  // Field positions in decoder_control_two: pin selects, then modes.
  localparam int CT2_SEL_LSB  = 0;
  localparam int CT2_SEL_STEP = 8;
  localparam int CT2_MODE_LSB = 24;
  // Reset values.
  localparam logic [DIV_W-1:0]   DIV_RST = 10'h000;
  localparam logic [EVT_W-1:0]   THR_RST = 8'hFF;
  localparam logic [SEL_W-1:0]   SEL_OFF = 5'h00;
  // Per-axis counting modes.
  localparam logic MODE_QUAD = 1'b0;
  localparam logic MODE_EDGE = 1'b1;
endpackage : qdc_pkg

// ==== qdc_spike_filter.sv ====
// Spike filter and edge detector for one channel input.
`timescale 1ns/1ps
module qdc_spike_filter #(
  parameter int LEN = qdc_pkg::FILT_LEN
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic sample_en,
  input  wire logic pin_in,
  output logic      filt_out,
  output logic      rise,
  output logic      fall
);
  import qdc_pkg::*;

  logic [LEN-1:0] hist_q;  // Last LEN samples, newest in bit 0.
  logic [LEN-1:0] hist_d;  // History after the current sample.

  // Next history is formed every cycle but only loaded on a sampling tick.
  always_comb begin
    hist_d = {hist_q[LEN-2:0], pin_in};
  end

  // The level only moves after LEN equal samples, so shorter spikes die here.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_q   <= '0;
      filt_out <= 1'b0;
      rise     <= 1'b0;
      fall     <= 1'b0;
    end else begin
      rise <= 1'b0;
      fall <= 1'b0;
      if (sample_en) begin
        hist_q <= hist_d;
        if ((&hist_d) && !filt_out) begin
          filt_out <= 1'b1;
          rise     <= 1'b1;
        end else if (!(|hist_d) && filt_out) begin
          filt_out <= 1'b0;
          fall     <= 1'b1;
        end
      end
    end
  end

  // The filtered level changes only right after a sampling tick.
  a_filt_on_tick: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(filt_out) |-> $past(sample_en)) else $error("filter moved off tick");
endmodule : qdc_spike_filter

// ==== qdc_axis_counter.sv ====
// Signed step counter for one axis, quadrature or edge mode.
`timescale 1ns/1ps
module qdc_axis_counter #(
  parameter int W = qdc_pkg::AXIS_W
) (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                axis_en,
  input  wire logic                count_mode,
  input  wire logic                level_a,
  input  wire logic                level_b,
  input  wire logic                edge_a,
  input  wire logic                edge_b,
  output logic signed [W-1:0]      steps_q
);
  import qdc_pkg::*;

  logic last_up_q;  // Last decoded direction, reused for double edges.
  logic step_up;    // Direction of the current step.
  logic any_edge;   // At least one channel moved this cycle.

  // A leads B counts up: up when new A differs from old B, or new B equals old A.
  always_comb begin
    any_edge = edge_a | edge_b;
    if (edge_a && edge_b) begin
      step_up = last_up_q;
    end else if (edge_a) begin
      step_up = level_a ^ (level_b ^ edge_b);
    end else begin
      step_up = ~(level_b ^ (level_a ^ edge_a));
    end
  end

  // Counter update; a disabled axis is held at zero.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      steps_q   <= '0;
      last_up_q <= 1'b1;
    end else if (!axis_en) begin
      steps_q   <= '0;
      last_up_q <= 1'b1;
    end else if (any_edge) begin
      if (count_mode == MODE_EDGE) begin
        steps_q <= steps_q + W'(1);
      end else begin
        last_up_q <= step_up;
        // Net signed step count wraps in two's complement.
        steps_q   <= step_up ? steps_q + W'(1) : steps_q - W'(1);
      end
    end
  end

  sequence s_single_a;
    axis_en && count_mode == MODE_QUAD && edge_a && !edge_b;
  endsequence

  // Expected values are cut to the counter width so that a wrap compares equal.
  a_axis_cleared: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !axis_en |=> steps_q == 0) else $error("disabled axis not zero");
  a_quad_dir: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_single_a |=> steps_q == W'($past(steps_q) + ($past(level_a ^ level_b) ? 1 : -1)))
    else $error("quadrature direction wrong");
  a_edge_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
    axis_en && count_mode == MODE_EDGE && (edge_a || edge_b) |=>
    steps_q == W'($past(steps_q) + 1)) else $error("edge mode miscounted");
endmodule : qdc_axis_counter

// ==== qdc_decoder.sv ====
// Three-axis quadrature decoder top: registers, sampling, counters.
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module qdc_decoder #(
  parameter int NGPIO = qdc_pkg::NUM_GPIO
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire logic [qdc_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [qdc_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [qdc_pkg::DATA_W-1:0]    reg_rdata,
  input  wire logic [NGPIO-1:0]              gpio_in,
  input  wire logic                          decoder_clock_gate,
  input  wire logic                          sleep_mode,
  input  wire logic                          low_power_rc_tick,
  output logic                               edge_irq,
  output logic                               wake_req
);
  import qdc_pkg::*;

  localparam int NPAIR = NGPIO / 2;  // Pin pairs reachable by a select.

  // Software-visible state.
  logic                 irq_en_q;        // Interrupt output enable.
  logic                 edge_irq_pending_q;  // Sticky threshold flag.
  logic [EVT_W-1:0]     edge_irq_threshold_q;  // Threshold on the edge count.
  logic [SEL_W-1:0]     pin_select_q [3];  // Pair select per axis, zero is off.
  logic [2:0]           axis_count_mode_q;  // One mode bit per axis.
  logic [DIV_W-1:0]     sampling_divider_setting_q;  // Interval minus one.
  logic [EVT_W-1:0]     overall_edge_counter_q;  // Cycles with an edge on any enabled channel.
  logic [DATA_W-1:0]    rdata_d;  // Read data before the output register.

  // Decoded write strobes.
  logic wr_ctrl_one;
  logic wr_ctrl_two;
  logic wr_div;
  logic clr_pending;
  logic clr_counter;

  // Sampling divider.
  logic [DIV_W-1:0] div_cnt_q;  // Cycles since the last divided tick.
  logic [DIV_W-1:0] div_last;   // Terminal count, floored for the rate limit.
  logic             div_tick;   // Divided-clock sampling tick.
  logic             sample_en;  // Tick actually used by the filters.

  // Channel wiring: channel c belongs to axis c/2, A when c is even.
  logic [5:0] ch_pin;
  logic [5:0] ch_level;
  logic [5:0] ch_rise;
  logic [5:0] ch_fall;
  logic [5:0] ch_edge;
  logic [2:0] axis_en;
  logic signed [AXIS_W-1:0] axis_steps [3];
  logic       any_edge;  // Some enabled channel had an edge this cycle.

  // Register port decode; writes land at any time, the gate only stalls sampling.
  always_comb begin
    wr_ctrl_one = reg_wr && reg_addr == ADDR_CTRL_ONE;
    wr_ctrl_two = reg_wr && reg_addr == ADDR_CTRL_TWO;
    wr_div      = reg_wr && reg_addr == ADDR_DIVIDER;
    clr_pending = wr_ctrl_one && reg_wdata[CT1_PENDING];
    clr_counter = wr_ctrl_one && reg_wdata[CT1_CLEAR];
  end

  // Control register one: enable and threshold.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_q             <= 1'b0;
      edge_irq_threshold_q <= THR_RST;
    end else if (wr_ctrl_one) begin
      irq_en_q             <= reg_wdata[CT1_IRQ_EN];
      edge_irq_threshold_q <= reg_wdata[CT1_THR_LSB +: EVT_W];
    end
  end

  // Control register two: pair selects and per-axis mode.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_select_q[0]   <= SEL_OFF;
      pin_select_q[1]   <= SEL_OFF;
      pin_select_q[2]   <= SEL_OFF;
      axis_count_mode_q <= {3{MODE_QUAD}};
    end else if (wr_ctrl_two) begin
      pin_select_q[0]   <= reg_wdata[CT2_SEL_LSB +: SEL_W];
      pin_select_q[1]   <= reg_wdata[CT2_SEL_LSB + CT2_SEL_STEP +: SEL_W];
      pin_select_q[2]   <= reg_wdata[CT2_SEL_LSB + 2*CT2_SEL_STEP +: SEL_W];
      axis_count_mode_q <= reg_wdata[CT2_MODE_LSB +: 3];
    end
  end

  // Divider setting register.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sampling_divider_setting_q <= DIV_RST;
    end else if (wr_div) begin
      sampling_divider_setting_q <= reg_wdata[DIV_W-1:0];
    end
  end

  // The interval is setting plus one cycles, but never shorter than the
  // 32 MHz limit allows; small settings are quietly stretched.
  always_comb begin
    if (sampling_divider_setting_q < DIV_W'(SAMP_MIN_CYC - 1)) begin
      div_last = DIV_W'(SAMP_MIN_CYC - 1);
    end else begin
      div_last = sampling_divider_setting_q;
    end
    div_tick = div_cnt_q >= div_last;
    // In sleep the divider is bypassed and the RC clock ticks drive sampling.
    if (!decoder_clock_gate) begin
      sample_en = 1'b0;
    end else if (sleep_mode) begin
      sample_en = low_power_rc_tick;
    end else begin
      sample_en = div_tick;
    end
  end

  // Divider counter; restarts while asleep so waking begins a full interval.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= '0;
    end else if (!decoder_clock_gate || sleep_mode || div_tick) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + DIV_W'(1);
    end
  end

  // Pin pair selection, filtering and edge detection per channel.
  genvar c;
  generate
    for (c = 0; c < 6; c++) begin : g_chan
      logic [SEL_W-1:0] sel;
      assign sel = pin_select_q[c/2];
      // Select n maps to pins 2n-2 (A) and 2n-1 (B); zero reads low.
      always_comb begin
        if (sel != SEL_OFF && int'(sel) <= NPAIR) begin
          ch_pin[c] = gpio_in[2*(int'(sel)-1) + (c % 2)];
        end else begin
          ch_pin[c] = 1'b0;
        end
      end
      qdc_spike_filter #(.LEN(FILT_LEN)) u_filt (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .sample_en (sample_en),
        .pin_in    (ch_pin[c]),
        .filt_out  (ch_level[c]),
        .rise      (ch_rise[c]),
        .fall      (ch_fall[c])
      );
      // Edges of a disabled axis are dropped here.
      assign ch_edge[c] = (ch_rise[c] | ch_fall[c]) & axis_en[c/2];
    end
  endgenerate

  // One counter per axis.
  genvar a;
  generate
    for (a = 0; a < 3; a++) begin : g_axis
      assign axis_en[a] = pin_select_q[a] != SEL_OFF && int'(pin_select_q[a]) <= NPAIR;
      qdc_axis_counter #(.W(AXIS_W)) u_axis (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .axis_en    (axis_en[a]),
        .count_mode (axis_count_mode_q[a]),
        .level_a    (ch_level[2*a]),
        .level_b    (ch_level[2*a+1]),
        .edge_a     (ch_edge[2*a]),
        .edge_b     (ch_edge[2*a+1]),
        .steps_q    (axis_steps[a])
      );
    end
  endgenerate

  assign any_edge = |ch_edge;

  // Overall edge counter; an edge in the clearing cycle survives as a count of one.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      overall_edge_counter_q <= '0;
    end else if (clr_counter) begin
      overall_edge_counter_q <= any_edge ? EVT_W'(1) : '0;
    end else if (any_edge) begin
      overall_edge_counter_q <= overall_edge_counter_q + EVT_W'(1);
    end
  end

  // Sticky pending flag: the threshold hit wins over a clear in the same cycle.
  // The counter is not stopped, so it can wrap below the threshold later.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_irq_pending_q <= 1'b0;
    end else if (overall_edge_counter_q >= edge_irq_threshold_q) begin
      edge_irq_pending_q <= 1'b1;
    end else if (clr_pending) begin
      edge_irq_pending_q <= 1'b0;
    end
  end

  // Interrupt and wake outputs, both registered.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_irq <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      edge_irq <= edge_irq_pending_q && irq_en_q;
      wake_req <= sleep_mode && any_edge;
    end
  end

  // Read multiplexer; unmapped offsets read zero.
  always_comb begin
    rdata_d = '0;
    case (reg_addr)
      ADDR_CTRL_ONE: begin
        rdata_d[CT1_IRQ_EN]             = irq_en_q;
        rdata_d[CT1_PENDING]            = edge_irq_pending_q;
        rdata_d[CT1_THR_LSB +: EVT_W]   = edge_irq_threshold_q;
      end
      ADDR_CTRL_TWO: begin
        rdata_d[CT2_SEL_LSB +: SEL_W]                  = pin_select_q[0];
        rdata_d[CT2_SEL_LSB + CT2_SEL_STEP +: SEL_W]   = pin_select_q[1];
        rdata_d[CT2_SEL_LSB + 2*CT2_SEL_STEP +: SEL_W] = pin_select_q[2];
        rdata_d[CT2_MODE_LSB +: 3]                     = axis_count_mode_q;
      end
      ADDR_DIVIDER:  rdata_d[DIV_W-1:0] = sampling_divider_setting_q;
      // Axis counts are sign-extended to the full word.
      ADDR_X_STEPS:  rdata_d = DATA_W'(axis_steps[0]);
      ADDR_Y_STEPS:  rdata_d = DATA_W'(axis_steps[1]);
      ADDR_Z_STEPS:  rdata_d = DATA_W'(axis_steps[2]);
      ADDR_EDGE_CNT: rdata_d[EVT_W-1:0] = overall_edge_counter_q;
      default:       rdata_d = '0;
    endcase
  end

  // Read data stands for exactly the cycle after the strobe.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= '0;
    end
  end

  // Helper: cycles since the last divided sampling tick.
  logic [DIV_W:0] gap_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= '0;
    end else if (sample_en || sleep_mode || !decoder_clock_gate) begin
      gap_q <= '0;
    end else if (!(&gap_q)) begin
      gap_q <= gap_q + (DIV_W+1)'(1);
    end
  end

  sequence s_read_x;
    reg_rd && reg_addr == ADDR_X_STEPS;
  endsequence

  sequence s_read_cnt;
    reg_rd && reg_addr == ADDR_EDGE_CNT;
  endsequence

  // Awake sampling never outruns the rate cap, and awake ticks never come back to back.
  a_samp_rate_cap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sample_en && !sleep_mode && $past(sample_en) == 1'b0 && $past(gap_q) != 0 |->
    gap_q >= (DIV_W+1)'(SAMP_MIN_CYC - 1)) else $error("sampling too fast");
  a_no_back_tick: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sample_en && !sleep_mode ##1 !sleep_mode |-> !sample_en)
    else $error("ticks back to back");
  a_sleep_bypass: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sleep_mode && decoder_clock_gate |-> sample_en == low_power_rc_tick)
    else $error("sleep tick not bypassed");

  // Overall count: one per edge cycle, zeroed by a clear unless an edge lands with it (then one), kept going past the interrupt.
  a_edge_count_inc: assert property (@(posedge sys_clk) disable iff (!rst_n)
    any_edge && !clr_counter |=> overall_edge_counter_q ==
    $past(overall_edge_counter_q) + 8'h01) else $error("edge count missed");
  a_edge_count_clr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clr_counter && !any_edge |=> overall_edge_counter_q == 0)
    else $error("edge count not cleared");
  a_clear_keeps_hit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clr_counter && any_edge |=> overall_edge_counter_q == 8'h01)
    else $error("edge lost in clearing cycle");
  a_count_past_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
    edge_irq_pending_q && any_edge && !clr_counter |=>
    overall_edge_counter_q != $past(overall_edge_counter_q))
    else $error("count stopped at irq");

  // Pending flag: set at the threshold, sticky, dropped only by a clear below it.
  a_pend_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    overall_edge_counter_q >= edge_irq_threshold_q |=> edge_irq_pending_q ##1
    edge_irq == $past(irq_en_q)) else $error("pending not raised");
  a_pend_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    edge_irq_pending_q && !clr_pending |=> edge_irq_pending_q)
    else $error("pending dropped");
  a_pend_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clr_pending && overall_edge_counter_q < edge_irq_threshold_q |=> !edge_irq_pending_q)
    else $error("pending not cleared");

  // Read data stand one cycle after a read strobe and are zero otherwise.
  a_read_x_steps: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_read_x |=> reg_rdata == DATA_W'($past(axis_steps[0]))) else $error("x read wrong");
  a_read_edge_cnt: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_read_cnt |=> reg_rdata == DATA_W'($past(overall_edge_counter_q)))
    else $error("edge count read wrong");
  a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == '0) else $error("read data not idle");

  // Wake requests come only from movement seen while asleep.
  a_wake_move: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sleep_mode && any_edge |=> wake_req) else $error("no wake on movement");
  a_wake_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !sleep_mode |=> !wake_req) else $error("wake while awake");
endmodule : qdc_decoder

// ==== qdc_motion_src.sv ====
// Behavioural model of the motion device that drives quadrature pairs onto the pins.
`timescale 1ns/1ps
module qdc_motion_src (
  input  wire logic        sys_clk,
  output logic      [31:0] gpio_out
);
  logic [1:0] ph_q [16];  // Phase index of each channel pair.

  // All pins start low, so every pair starts in phase zero.
  initial begin
    gpio_out = 32'h0;
    foreach (ph_q[i]) ph_q[i] = 2'h0;
  end

  // Maps a phase index to {B, A}; channel A leads B when moving forward.
  function automatic logic [1:0] pat(input logic [1:0] i);
    return (i == 2'h0) ? 2'h0 : (i == 2'h1) ? 2'h1 : (i == 2'h2) ? 2'h3 : 2'h2;
  endfunction : pat

  // Moves pair p by delta phases just after an edge, then holds for hold cycles.
  // A delta of two flips both channels at once, which a real encoder never does.
  task automatic move(input int p, input int delta, input int hold);
    ph_q[p] = ph_q[p] + delta[1:0];
    @(posedge sys_clk);
    gpio_out[2*p +: 2] <= pat(ph_q[p]);
    repeat (hold) @(posedge sys_clk);
  endtask : move

  // Flips channel A of pair p for one cycle only, far shorter than three samples.
  task automatic spike(input int p);
    @(posedge sys_clk);
    gpio_out[2*p] <= ~gpio_out[2*p];
    @(posedge sys_clk);
    gpio_out[2*p] <= ~gpio_out[2*p];
    repeat (40) @(posedge sys_clk);
  endtask : spike
endmodule : qdc_motion_src

// ==== tb_qdc_decoder.sv ====
// Self-checking testbench for the three-axis quadrature decoder.
`timescale 1ns/1ps
`define CHK(g, e) check_val(g, e)
module tb_qdc_decoder;
  import qdc_pkg::*;
  localparam int G = 40;               // Hold per phase, above three slowest samples.
  logic                     sys_clk;   // Bench clock.
  logic                     rst_n;     // Active-low reset.
  logic                     reg_wr;    // Write strobe.
  logic                     reg_rd;    // Read strobe.
  logic [ADDR_W-1:0]        reg_addr;  // Register address.
  logic [DATA_W-1:0]        reg_wdata; // Write data.
  logic [DATA_W-1:0]        reg_rdata; // Read data from the design.
  logic [31:0]              gpio;      // Pins driven by the motion model.
  logic                     gate;      // Block clock enable.
  logic                     sleep;     // System sleep flag.
  logic                     rc_tick;   // Low-power tick pulse.
  logic                     edge_irq;  // Interrupt output.
  logic                     wake_req;  // Wake pulse.
  logic                     rd_seen;   // A read was taken at the last edge.
  logic                     wake_seen; // Sticky copy of the wake pulse.
  logic [3:0]               rc_cnt;    // Tick divider.
  logic [DATA_W-1:0]        exp_q[$];  // Expected read data, oldest first.
  logic signed [AXIS_W-1:0] exp_x, exp_y, exp_z;
  logic [EVT_W-1:0]         exp_e, thr;
  int                       fail_count, check_count, n, seed_v;

  qdc_decoder qdc_decoder_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_in(gpio),
    .decoder_clock_gate(gate), .sleep_mode(sleep), .low_power_rc_tick(rc_tick),
    .edge_irq(edge_irq), .wake_req(wake_req));
  qdc_motion_src qdc_motion_src_inst (.sys_clk(sys_clk), .gpio_out(gpio));

  // Free-running clock at 100 MHz.
  always #5 sys_clk = ~sys_clk;

  // One tick every sixteen cycles stands in for the slow RC clock.
  always @(posedge sys_clk) begin
    rc_cnt  <= rc_cnt + 4'h1;
    rc_tick <= (rc_cnt == 4'hF);
  end

  // Notes taken reads and any wake pulse, since both last a single cycle.
  always @(posedge sys_clk) begin
    rd_seen <= reg_rd;
    if (wake_req === 1'b1) wake_seen <= 1'b1;
  end

  // Read data stand only in the cycle after the read, so compare mid-cycle.
  always @(negedge sys_clk) begin
    if (rd_seen) `CHK(reg_rdata, exp_q.pop_front());
  end

  // Counts one comparison and reports a mismatch at once.
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      fail_count++;
    end
  endtask : check_val

  // One-cycle register write.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // One-cycle register read; the monitor compares the answer.
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask : rd

  // Sign-extends an axis count the way the register port presents it.
  function automatic logic [31:0] sx(input logic signed [AXIS_W-1:0] v);
    return {{16{v[15]}}, v};
  endfunction : sx

  // Moves pair p k times by d phases.
  task automatic stp(input int p, input int d, input int k, input int hold);
    repeat (k) qdc_motion_src_inst.move(p, d, hold);
  endtask : stp

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks=%0d errors=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // Cuts a hang short well beyond the under two thousand cycles the tests need.
  initial begin
    repeat (30000) @(posedge sys_clk);
    fail_count++;
    conclude();
  end

  // Main sequence.
  initial begin
    {sys_clk, rst_n, reg_wr, reg_rd, sleep, rc_tick, rd_seen, wake_seen} = 8'h00;
    {reg_addr, reg_wdata, rc_cnt, fail_count, check_count} = '0;
    gate = 1'b1;
    {exp_x, exp_y, exp_z, exp_e} = '0;
    repeat (8) @(posedge sys_clk);
    rst_n  <= 1'b1;
    seed_v = $urandom(98);
    rd(ADDR_CTRL_ONE, 32'h0000FF00);
    rd(ADDR_CTRL_TWO, 32'h0);
    rd(8'h1C, 32'h0);
    for (int a = 8; a <= 24; a += 4) rd(a[7:0], 32'h0);
    n = 3 + $urandom % 5;
    wr(ADDR_DIVIDER, n);
    wr(ADDR_CTRL_TWO, 32'h04030201);
    rd(ADDR_DIVIDER, n);
    rd(ADDR_CTRL_TWO, 32'h04030201);
    // X counts up, then down, then up, then one double step.
    n = 1 + $urandom % 6;
    stp(0, 1, n, G);
    exp_x += n;
    exp_e += n;
    n = 1 + $urandom % 6;
    stp(0, -1, n, G);
    exp_x -= n;
    exp_e += n;
    stp(0, 1, 2, G);
    stp(0, 2, 1, G);
    exp_x += 3;
    exp_e += 3;
    qdc_motion_src_inst.spike(0);
    rd(ADDR_X_STEPS, sx(exp_x));
    n = 4 * (1 + $urandom % 2);
    stp(1, -1, n, G);
    exp_y -= n;
    exp_e += n;
    rd(ADDR_Y_STEPS, sx(exp_y));
    n = 1 + $urandom % 6;
    stp(2, -1, n, G);
    stp(2, 2, 1, G);
    exp_z += n + 1;
    exp_e += n + 1;
    rd(ADDR_Z_STEPS, sx(exp_z));
    rd(ADDR_EDGE_CNT, {24'h0, exp_e});
    wr(ADDR_CTRL_TWO, 32'h04030001);
    rd(ADDR_Y_STEPS, 32'h0);
    // Pins that move and return while the block is stalled leave no trace.
    gate <= 1'b0;
    stp(0, 1, 1, G);
    stp(0, -1, 1, G);
    gate <= 1'b1;
    repeat (G) @(posedge sys_clk);
    rd(ADDR_X_STEPS, sx(exp_x));
    // Threshold two edges ahead of the present count.
    thr = exp_e + 8'h02;
    wr(ADDR_CTRL_ONE, {16'h0, thr, 8'h01});
    stp(2, 1, 1, G);
    exp_e += 1;
    `CHK({31'h0, edge_irq}, 32'h0);
    rd(ADDR_CTRL_ONE, {16'h0, thr, 8'h01});
    stp(2, 1, 1, G);
    exp_e += 1;
    `CHK({31'h0, edge_irq}, 32'h1);
    rd(ADDR_CTRL_ONE, {16'h0, thr, 8'h03});
    stp(2, 1, 1, G);
    exp_e += 1;
    rd(ADDR_EDGE_CNT, {24'h0, exp_e});
    wr(ADDR_CTRL_ONE, {16'h0, thr, 8'h07});
    repeat (3) @(posedge sys_clk);
    rd(ADDR_EDGE_CNT, 32'h0);
    // The count still stood one above the threshold when both clears landed, so pending holds.
    rd(ADDR_CTRL_ONE, {16'h0, thr, 8'h03});
    wr(ADDR_CTRL_ONE, {16'h0, thr, 8'h03});
    rd(ADDR_CTRL_ONE, {16'h0, thr, 8'h01});
    `CHK({31'h0, edge_irq}, 32'h0);
    `CHK({31'h0, wake_seen}, 32'h0);
    // Asleep, the block samples on the slow tick and asks to wake.
    sleep <= 1'b1;
    stp(0, 1, 1, 100);
    exp_x += 1;
    `CHK({31'h0, wake_seen}, 32'h1);
    rd(ADDR_X_STEPS, sx(exp_x));
    rd(ADDR_EDGE_CNT, 32'h1);
    sleep <= 1'b0;
    repeat (4) @(posedge sys_clk);
    // A select beyond the last pin pair disables the axis as well.
    wr(ADDR_CTRL_TWO, 32'h04030011);
    rd(ADDR_CTRL_TWO, 32'h04030011);
    rd(ADDR_X_STEPS, 32'h0);
    conclude();
  end
endmodule : tb_qdc_decoder
